// ### rtl/otd_ctrl.sv
// Overtravel inhibit and rotation-direction control, top level.
// Assumes commands, motion flags and the control mode come from logic on clk;
// limit switches and the strap are raw pins.
//
// Functional notes
// - Direction bit, reset 0: 0 forward is ccw, 1 forward is cw.
// - Reverse mode only flips the sign of commanded motion, nothing else.
// - Strap present on the encoder connector forces reverse mode.
// - Forward limit enabled: low allows forward, high or open blocks it only.
// - Reverse limit enabled: low allows reverse, high or open blocks it only.
// - Forward limit enable bit: 0 honours input, 1 ignores it.
// - Reverse limit enable bit: 0 honours input, 1 ignores it.
// - Overtravel during motion forces a stop by the chosen stop method.
// - Stop-method bit, reset 0, and post-stop action bit are provided.
// - Stop bit 0 stops as servo-off; 1 decelerates with emergency torque.
// - After deceleration stop: bit 0 servo off, bit 1 zero clamp.
// - Torque control mode always stops as servo-off on overtravel.
//
// The plain strobed port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
module otd_ctrl
	import otd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Register port
	input wire logic [OTD_ADDR_W-1:0] addr,
	input wire logic [OTD_DATA_W-1:0] wdata,
	input wire logic wr,
	input wire logic rd,
	output logic [OTD_DATA_W-1:0] rdata,
	// Pins
	input wire logic fwd_limit_in,
	input wire logic rev_limit_in,
	input wire logic rev_strap_in,
	// Motion commands and status
	input wire logic cmd_fwd,
	input wire logic cmd_rev,
	input wire logic motor_moving,
	input wire logic motor_stopped,
	input wire logic torque_mode,
	// Motor drive outputs
	output logic drive_ccw,
	output logic drive_cw,
	output logic soff_stop,
	output logic decel_stop,
	output logic zero_clamp,
	output logic servo_off,
	output logic reverse_mode,
	// Interrupt
	output logic irq
);

	////////////////////////////////////////////////////////////////
	// Declarations
	logic [OTD_DATA_W-1:0] function_switch_a_reg;
	logic [OTD_DATA_W-1:0] function_switch_b_reg;
	logic [2:0] sync_lvl;
	logic fwd_lvl;
	logic rev_lvl;
	logic strap_lvl;
	logic fwd_block;
	logic rev_block;
	logic rev_mode;
	logic ot_hit;
	logic use_decel;
	otd_state_e state_reg;
	otd_state_e state_next;
	logic mot_fwd;
	logic mot_rev;
	logic fwd_block_reg;
	logic rev_block_reg;
	logic [OTD_EV_N-1:0] evt;
	logic [OTD_EV_N-1:0] evt_reg;
	logic [OTD_EV_N-1:0] mask_reg;
	logic [OTD_DATA_W-1:0] rdata_next;

	function automatic logic hit(input logic [OTD_ADDR_W-1:0] a, input logic [OTD_ADDR_W-1:0] o);
		hit = (a == o);
	endfunction

	////////////////////////////////////////////////////////////////
	// Pin synchronisers
	otd_sync #(
		.N(3),
		.RST_VAL({OTD_RST_STRAP, OTD_RST_LIMIT, OTD_RST_LIMIT})
	) u_sync (
		.clk(clk),
		.rstn(rstn),
		.pin({rev_strap_in, rev_limit_in, fwd_limit_in}),
		.lvl(sync_lvl)
	);

	assign fwd_lvl = sync_lvl[0];
	assign rev_lvl = sync_lvl[1];
	assign strap_lvl = sync_lvl[2];

	////////////////////////////////////////////////////////////////
	// Configuration switches
	always_ff @(posedge clk)
	begin
		if (!rstn)
			function_switch_a_reg <= OTD_RST_SWA;
		else if (wr && hit(addr, OTD_OFS_SWA))
			function_switch_a_reg <= wdata;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			function_switch_b_reg <= OTD_RST_SWB;
		else if (wr && hit(addr, OTD_OFS_SWB))
			function_switch_b_reg <= wdata;
	end

	////////////////////////////////////////////////////////////////
	// Direction and inhibit decode
	// Strap wins so a machine can be standardised without touching the switch
	assign rev_mode = strap_lvl | function_switch_b_reg[OTD_B_DIR];
	// Open switch reads high, so a broken wire also blocks motion
	assign fwd_block = fwd_lvl & ~function_switch_a_reg[OTD_B_FWD_OFF];
	assign rev_block = rev_lvl & ~function_switch_a_reg[OTD_B_REV_OFF];
	assign ot_hit = (fwd_block & cmd_fwd) | (rev_block & cmd_rev);
	// Torque mode cannot decelerate on a torque figure, so it always coasts or brakes
	assign use_decel = function_switch_a_reg[OTD_B_STOP_DECEL] & ~torque_mode;

	////////////////////////////////////////////////////////////////
	// Overtravel stop sequence
	always_comb
	begin
		state_next = state_reg;
		case (state_reg)
			OTD_RUN:
			begin
				if (ot_hit && motor_moving)
					state_next = use_decel ? OTD_DECEL : OTD_SOFF_STOP;
			end
			OTD_DECEL:
			begin
				if (motor_stopped)
				begin
					if (function_switch_a_reg[OTD_B_POST_CLAMP])
						state_next = OTD_CLAMP;
					else
						state_next = OTD_SERVO_OFF;
				end
			end
			OTD_SOFF_STOP, OTD_CLAMP, OTD_SERVO_OFF:
			begin
				if (!ot_hit)
					state_next = OTD_RUN;
			end
			default:
			begin
				state_next = OTD_RUN;
			end
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			state_reg <= OTD_RUN;
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////
	// Motion gating and direction mapping
	// Only the blocked direction is cut; moving back off the switch stays legal
	assign mot_fwd = cmd_fwd & ~cmd_rev & ~fwd_block & (state_next == OTD_RUN);
	assign mot_rev = cmd_rev & ~cmd_fwd & ~rev_block & (state_next == OTD_RUN);

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			drive_ccw <= 1'b0;
			drive_cw <= 1'b0;
		end
		else
		begin
			drive_ccw <= rev_mode ? mot_rev : mot_fwd;
			drive_cw <= rev_mode ? mot_fwd : mot_rev;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			soff_stop <= 1'b0;
			decel_stop <= 1'b0;
			zero_clamp <= 1'b0;
			servo_off <= 1'b0;
			reverse_mode <= 1'b0;
		end
		else
		begin
			soff_stop <= (state_next == OTD_SOFF_STOP);
			decel_stop <= (state_next == OTD_DECEL);
			zero_clamp <= (state_next == OTD_CLAMP);
			servo_off <= (state_next == OTD_SERVO_OFF);
			reverse_mode <= rev_mode;
		end
	end

	////////////////////////////////////////////////////////////////
	// Events and interrupt
	always_ff @(posedge clk)
	begin
		if (!rstn)
		begin
			// Match the synchronisers' blocked reset level, so release gives no false edge
			fwd_block_reg <= OTD_RST_LIMIT;
			rev_block_reg <= OTD_RST_LIMIT;
		end
		else
		begin
			fwd_block_reg <= fwd_block;
			rev_block_reg <= rev_block;
		end
	end

	assign evt[OTD_EV_FWD] = fwd_block & ~fwd_block_reg;
	assign evt[OTD_EV_REV] = rev_block & ~rev_block_reg;
	assign evt[OTD_EV_DONE] = (state_reg == OTD_DECEL) && (state_next != OTD_DECEL);

	otd_irq u_irq (
		.clk(clk),
		.rstn(rstn),
		.evt(evt),
		.evt_w1c(wr && hit(addr, OTD_OFS_EVT)),
		.mask_wr(wr && hit(addr, OTD_OFS_MASK)),
		.wdata(wdata[OTD_EV_N-1:0]),
		.evt_reg(evt_reg),
		.mask_reg(mask_reg),
		.irq(irq)
	);

	////////////////////////////////////////////////////////////////
	// Read back, one cycle after the strobe; unmapped reads zero
	always_comb
	begin
		rdata_next = '0;
		case (addr)
			OTD_OFS_SWA: rdata_next = function_switch_a_reg;
			OTD_OFS_SWB: rdata_next = function_switch_b_reg;
			OTD_OFS_STATE:
			begin
				rdata_next[OTD_S_FWD_BLK] = fwd_block;
				rdata_next[OTD_S_REV_BLK] = rev_block;
				rdata_next[OTD_S_REV_MODE] = rev_mode;
				rdata_next[OTD_S_STRAP] = strap_lvl;
				rdata_next[OTD_S_STATE +: 5] = state_reg;
			end
			OTD_OFS_EVT: rdata_next[OTD_EV_N-1:0] = evt_reg;
			OTD_OFS_MASK: rdata_next[OTD_EV_N-1:0] = mask_reg;
			default: rdata_next = '0;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			rdata <= '0;
		else if (rd)
			rdata <= rdata_next;
		else
			rdata <= '0;
	end

	////////////////////////////////////////////////////////////////
	// Checks
	chk_sync_two_stage: assert property (@(posedge clk) disable iff (!rstn)
		$past(rstn, 2) |-> (fwd_lvl == $past(fwd_limit_in, 2)))
		else $error("limit input not delayed by two stages");

	chk_strap_forces_rev: assert property (@(posedge clk) disable iff (!rstn)
		strap_lvl |=> reverse_mode)
		else $error("strap did not force reverse mode");

	chk_default_dir: assert property (@(posedge clk) disable iff (!rstn)
		(!strap_lvl && !function_switch_b_reg[OTD_B_DIR]) |=> !reverse_mode)
		else $error("standard direction not kept");

	chk_fwd_limit_blocks: assert property (@(posedge clk) disable iff (!rstn)
		(fwd_lvl && !function_switch_a_reg[OTD_B_FWD_OFF] && cmd_fwd)
		|=> !(reverse_mode ? drive_cw : drive_ccw))
		else $error("forward motion while forward limit active");

	chk_rev_limit_ignore: assert property (@(posedge clk) disable iff (!rstn)
		(function_switch_a_reg[OTD_B_REV_OFF] && rev_lvl && state_reg == OTD_RUN && cmd_rev
		&& !cmd_fwd) |=> (drive_ccw || drive_cw))
		else $error("disabled reverse limit still blocks");

	chk_fwd_limit_ignore: assert property (@(posedge clk) disable iff (!rstn)
		(function_switch_a_reg[OTD_B_FWD_OFF] && state_reg == OTD_RUN && cmd_fwd
		&& !cmd_rev && !motor_moving) |=> (drive_ccw || drive_cw))
		else $error("disabled forward limit still blocks");

	chk_rev_limit_allows: assert property (@(posedge clk) disable iff (!rstn)
		(rev_block && state_reg == OTD_RUN && cmd_fwd && !cmd_rev && !fwd_block)
		|=> (drive_ccw || drive_cw))
		else $error("reverse limit wrongly blocks forward");

	chk_dir_invert: assert property (@(posedge clk) disable iff (!rstn)
		(rev_mode && mot_fwd) |=> (drive_cw && !drive_ccw))
		else $error("reverse mode did not invert motion");

	chk_torque_soff: assert property (@(posedge clk) disable iff (!rstn)
		(state_reg == OTD_RUN && ot_hit && motor_moving && torque_mode)
		|=> (state_reg == OTD_SOFF_STOP) ##0 soff_stop)
		else $error("torque mode did not stop as servo-off");

	chk_decel_select: assert property (@(posedge clk) disable iff (!rstn)
		(state_reg == OTD_RUN && ot_hit && motor_moving && !torque_mode
		&& function_switch_a_reg[OTD_B_STOP_DECEL]) |=> decel_stop)
		else $error("deceleration stop not chosen");

	chk_post_stop: assert property (@(posedge clk) disable iff (!rstn)
		(state_reg == OTD_DECEL && motor_stopped)
		|=> (zero_clamp == $past(function_switch_a_reg[OTD_B_POST_CLAMP]))
		&& (servo_off != zero_clamp))
		else $error("wrong action after deceleration stop");

	chk_ot_stops: assert property (@(posedge clk) disable iff (!rstn)
		(state_reg == OTD_RUN && ot_hit && motor_moving)
		|=> (soff_stop || decel_stop) && !drive_ccw && !drive_cw)
		else $error("overtravel did not stop the motor");

endmodule

// ### pkg/otd_pkg.sv
// Package for the overtravel and rotation-direction control block.
// Assumes one 100 MHz clock and a synchronous active-low reset.
package otd_pkg;

	////////////////////////////////////////////////////////////////
	// Register port
	localparam int OTD_ADDR_W = 3;
	localparam int OTD_DATA_W = 16;
	localparam logic [2:0] OTD_OFS_SWA = 3'h0;
	localparam logic [2:0] OTD_OFS_SWB = 3'h1;
	localparam logic [2:0] OTD_OFS_STATE = 3'h2;
	localparam logic [2:0] OTD_OFS_EVT = 3'h3;
	localparam logic [2:0] OTD_OFS_MASK = 3'h4;

	////////////////////////////////////////////////////////////////
	// Field positions
	localparam int OTD_B_DIR = 0;
	localparam int OTD_B_FWD_OFF = 2;
	localparam int OTD_B_REV_OFF = 3;
	localparam int OTD_B_STOP_DECEL = 8;
	localparam int OTD_B_POST_CLAMP = 9;
	localparam int OTD_S_FWD_BLK = 0;
	localparam int OTD_S_REV_BLK = 1;
	localparam int OTD_S_REV_MODE = 2;
	localparam int OTD_S_STRAP = 3;
	localparam int OTD_S_STATE = 8;
	localparam int OTD_EV_FWD = 0;
	localparam int OTD_EV_REV = 1;
	localparam int OTD_EV_DONE = 2;
	localparam int OTD_EV_N = 3;

	////////////////////////////////////////////////////////////////
	// Reset values
	localparam logic [15:0] OTD_RST_SWA = 16'h0000;
	localparam logic [15:0] OTD_RST_SWB = 16'h0000;
	localparam logic [2:0] OTD_RST_EVT = 3'h0;
	localparam logic [2:0] OTD_RST_MASK = 3'h0;
	localparam logic OTD_RST_LIMIT = 1'b1;
	localparam logic OTD_RST_STRAP = 1'b0;
	localparam int OTD_SYNC_STAGES = 2;

	////////////////////////////////////////////////////////////////
	// Stop sequence states
	typedef enum logic [4:0] {
		OTD_RUN = 5'h01,
		OTD_SOFF_STOP = 5'h02,
		OTD_DECEL = 5'h04,
		OTD_CLAMP = 5'h08,
		OTD_SERVO_OFF = 5'h10
	} otd_state_e;

endpackage

// ### rtl/otd_sync.sv
// Two-stage synchroniser for the limit switches and the strap.
// Assumes the inputs are asynchronous pins; each bit has its own reset value.
`timescale 1ns/1ps
module otd_sync
	import otd_pkg::*;
#(
	parameter int N = 3,
	parameter logic [N-1:0] RST_VAL = '0
)
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Pins and synchronised levels
	input wire logic [N-1:0] pin,
	output logic [N-1:0] lvl
);

	////////////////////////////////////////////////////////////////
	// First stage feeds only the second stage
	genvar i;
	generate
		for (i = 0; i < N; i++)
		begin : g_bit
			logic meta_reg;
			logic hold_reg;
			always_ff @(posedge clk)
			begin
				if (!rstn)
				begin
					meta_reg <= RST_VAL[i];
					hold_reg <= RST_VAL[i];
				end
				else
				begin
					meta_reg <= pin[i];
					hold_reg <= meta_reg;
				end
			end
			assign lvl[i] = hold_reg;
		end
	endgenerate

endmodule

// ### rtl/otd_irq.sv
// Sticky event flags, mask and level interrupt.
// Assumes one-cycle event pulses and one-cycle write strobes from the owner.
`timescale 1ns/1ps
module otd_irq
	import otd_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic rstn,
	// Events and register writes
	input wire logic [OTD_EV_N-1:0] evt,
	input wire logic evt_w1c,
	input wire logic mask_wr,
	input wire logic [OTD_EV_N-1:0] wdata,
	// State and interrupt
	output logic [OTD_EV_N-1:0] evt_reg,
	output logic [OTD_EV_N-1:0] mask_reg,
	output logic irq
);

	logic [OTD_EV_N-1:0] evt_next;

	// A new event beats a clear in the same cycle
	always_comb
	begin
		evt_next = evt_reg;
		if (evt_w1c)
			evt_next = evt_next & ~wdata;
		evt_next = evt_next | evt;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			evt_reg <= OTD_RST_EVT;
		else
			evt_reg <= evt_next;
	end

	always_ff @(posedge clk)
	begin
		if (!rstn)
			mask_reg <= OTD_RST_MASK;
		else if (mask_wr)
			mask_reg <= wdata;
	end

	assign irq = |(evt_reg & mask_reg);

	chk_set_beats_clear: assert property (@(posedge clk) disable iff (!rstn)
		(evt[OTD_EV_FWD] && evt_w1c) |=> evt_reg[OTD_EV_FWD])
		else $error("event lost against clear");

endmodule

// ### bench/otd_motor_model.sv
// Behavioural motor, limit switches and encoder strap beside the control block.
// Assumes the bench sets switch levels, strap and run-down time on clk.
`timescale 1ns/1ps
module otd_motor_model
	import otd_pkg::*;
(
	// Clock
	input wire logic clk,
	// Bench controls
	input wire logic fwd_hit,
	input wire logic rev_hit,
	input wire logic strap_on,
	input wire logic [7:0] run_down,
	// Drive from the block
	input wire logic drive_ccw,
	input wire logic drive_cw,
	// Pins and motion status
	output logic fwd_limit_in,
	output logic rev_limit_in,
	output logic rev_strap_in,
	output logic motor_moving,
	output logic motor_stopped
);
	logic [7:0] spin_cnt;

	////////////////////////////////////////////////////////////////
	// Switches open (high) at overtravel, at 0 V otherwise
	assign fwd_limit_in = fwd_hit;
	assign rev_limit_in = rev_hit;
	assign rev_strap_in = strap_on;

	////////////////////////////////////////////////////////////////
	// Shaft keeps turning run_down cycles after drive ends, a crude inertia
	initial spin_cnt = 8'h00;
	always @(posedge clk)
	begin
		if (drive_ccw | drive_cw)
			spin_cnt <= run_down;
		else if (spin_cnt != 8'h00)
			spin_cnt <= spin_cnt - 8'h01;
	end
	assign motor_moving = (spin_cnt != 8'h00);
	assign motor_stopped = (spin_cnt == 8'h00);
endmodule

// ### bench/otd_ctrl_tb.sv
// Self-checking bench for the overtravel and direction control block.
// Assumes the motor model answers on the same clock; reads checked from a queue.
`timescale 1ns/1ps
module otd_ctrl_tb;
	import otd_pkg::*;
	logic clk, rstn, wr, rd, cmd_fwd, cmd_rev, torque_mode, fwd_hit, rev_hit, strap_on, rd_q;
	logic [2:0] addr;
	logic [15:0] wdata, rdata;
	logic [7:0] run_down;
	logic fwd_limit_in, rev_limit_in, rev_strap_in, motor_moving, motor_stopped;
	logic drive_ccw, drive_cw, soff_stop, decel_stop, zero_clamp, servo_off, reverse_mode, irq;
	logic [15:0] exp_q[$];
	logic [31:0] seed;
	int bad_count, checks;

	otd_ctrl u_otd_ctrl (.clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
		.rev_strap_in(rev_strap_in), .cmd_fwd(cmd_fwd), .cmd_rev(cmd_rev),
		.motor_moving(motor_moving), .motor_stopped(motor_stopped), .torque_mode(torque_mode),
		.drive_ccw(drive_ccw), .drive_cw(drive_cw), .soff_stop(soff_stop),
		.decel_stop(decel_stop), .zero_clamp(zero_clamp), .servo_off(servo_off),
		.reverse_mode(reverse_mode), .irq(irq));
	otd_motor_model u_otd_motor_model (.clk(clk), .fwd_hit(fwd_hit), .rev_hit(rev_hit),
		.strap_on(strap_on), .run_down(run_down), .drive_ccw(drive_ccw), .drive_cw(drive_cw),
		.fwd_limit_in(fwd_limit_in), .rev_limit_in(rev_limit_in),
		.rev_strap_in(rev_strap_in), .motor_moving(motor_moving),
		.motor_stopped(motor_stopped));

	////////////////////////////////////////////////////////////////
	// Helpers
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("[ERR] %0t seen %h exp %h", $time, seen, exp);
		end
	endtask
	task automatic waitc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Order: ccw cw soff decel clamp servo_off reverse irq
	task automatic outs(input logic [7:0] e);
		check({8'h00, drive_ccw, drive_cw, soff_stop, decel_stop, zero_clamp, servo_off,
			reverse_mode, irq}, {8'h00, e});
	endtask
	task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	// Read data stand only in the cycle after the strobe, so look mid-cycle
	task automatic rd_reg(input logic [2:0] a, input logic [15:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		exp_q.push_back(e);
		@(posedge clk);
		rd <= 1'b0;
	endtask
	always @(posedge clk) rd_q <= rd;
	always @(negedge clk)
	begin
		if (rd_q === 1'b1)
			check(rdata, exp_q.pop_front());
	end
	task automatic summarize;
		if (bad_count == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Clock and watchdog
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial
	begin
		#300us;
		bad_count++;
		summarize();
	end

	////////////////////////////////////////////////////////////////
	// Scenarios
	initial
	begin
		{rstn, wr, rd, cmd_fwd, cmd_rev, torque_mode, fwd_hit, rev_hit, strap_on} = '0;
		addr = 3'h0;
		wdata = 16'h0000;
		run_down = 8'h0A;
		seed = 32'd11910;
		bad_count = 0;
		checks = 0;
		waitc(20);
		rstn <= 1'b1;
		waitc(5);
		outs(8'h00);
		rd_reg(OTD_OFS_SWA, 16'h0000);
		rd_reg(OTD_OFS_SWB, 16'h0000);
		rd_reg(OTD_OFS_STATE, 16'h0100);
		// Direction: bit, then strap overriding a cleared bit
		cmd_fwd <= 1'b1;
		waitc(4);
		outs(8'h80);
		wr_reg(OTD_OFS_SWB, 16'h0001);
		waitc(4);
		outs(8'h42);
		wr_reg(OTD_OFS_SWB, 16'h0000);
		strap_on <= 1'b1;
		waitc(5);
		outs(8'h42);
		rd_reg(OTD_OFS_STATE, 16'h010C);
		strap_on <= 1'b0;
		waitc(5);
		// Forward overtravel, servo-off style stop, interrupt on
		wr_reg(OTD_OFS_MASK, 16'h0001);
		fwd_hit <= 1'b1;
		waitc(1);
		outs(8'h80);
		// Clear lands on the edge of the new forward event; the event must survive
		wr_reg(OTD_OFS_EVT, 16'h0001);
		waitc(4);
		outs(8'h21);
		rd_reg(OTD_OFS_STATE, 16'h0201);
		rd_reg(OTD_OFS_EVT, 16'h0001);
		cmd_fwd <= 1'b0;
		cmd_rev <= 1'b1;
		waitc(5);
		outs(8'h41);
		wr_reg(OTD_OFS_EVT, 16'h0007);
		wr_reg(OTD_OFS_MASK, 16'h0000);
		waitc(1);
		outs(8'h40);
		cmd_rev <= 1'b0;
		fwd_hit <= 1'b0;
		waitc(12);
		// Reverse overtravel, deceleration stop, both post-stop actions
		for (int k = 0; k < 2; k++)
		begin
			wr_reg(OTD_OFS_SWA, k ? 16'h0300 : 16'h0100);
			cmd_rev <= 1'b1;
			waitc(6);
			rev_hit <= 1'b1;
			waitc(5);
			outs(8'h10);
			waitc(20);
			outs(k ? 8'h08 : 8'h04);
			rd_reg(OTD_OFS_EVT, 16'h0006);
			cmd_rev <= 1'b0;
			cmd_fwd <= 1'b1;
			waitc(5);
			outs(8'h80);
			cmd_fwd <= 1'b0;
			rev_hit <= 1'b0;
			wr_reg(OTD_OFS_EVT, 16'h0007);
			waitc(12);
		end
		// Torque mode ignores the deceleration choice
		torque_mode <= 1'b1;
		cmd_fwd <= 1'b1;
		waitc(6);
		fwd_hit <= 1'b1;
		waitc(5);
		outs(8'h20);
		{cmd_fwd, fwd_hit, torque_mode} <= 3'b000;
		waitc(12);
		// Both limit inputs switched off
		wr_reg(OTD_OFS_SWA, 16'h000C);
		{fwd_hit, rev_hit, cmd_fwd} <= 3'b111;
		waitc(6);
		outs(8'h80);
		cmd_fwd <= 1'b0;
		cmd_rev <= 1'b1;
		waitc(4);
		outs(8'h40);
		{fwd_hit, rev_hit, cmd_rev} <= 3'b000;
		waitc(12);
		// Read-only and unmapped places, random stored bits
		wr_reg(OTD_OFS_STATE, 16'hFFFF);
		wr_reg(3'h6, 16'hFFFF);
		rd_reg(OTD_OFS_STATE, 16'h0100);
		rd_reg(3'h5, 16'h0000);
		repeat (4)
		begin
			seed = xs(seed);
			wr_reg(OTD_OFS_SWB, seed[15:0]);
			rd_reg(OTD_OFS_SWB, seed[15:0]);
			wr_reg(OTD_OFS_SWA, seed[31:16]);
			rd_reg(OTD_OFS_SWA, seed[31:16]);
		end
		waitc(4);
		summarize();
	end
endmodule
